// [design/link_interrupt_event_bank.sv]
// interrupt event bank with set/clear/mask registers on an avalon-mm slave
//
// Function
// - event bit sets on its source event (an edge or a level, per bit) or set-address write of one.
// - event bit clears by writing one at the clear address; bit 16 also clears on bus reset.
// - reads return events ANDed with the interrupt mask.
// - bits 31 and 28 always read zero.
// - bit 30 sets when an enabled general-purpose input asserts.
// - bit 29 is owned by software, no hardware source.
// - bit 27 sets when late-ack enabled and fifo, busy or tardy ack.
// - bit 26 sets on received phy byte; byte readable in bits 23-16.
// - as cycle master, bit 25 sets if cycle start to gap exceeds 125 us.
// - overlong cycle clears the cycle master enable bit 21.
// - bit 24 sets when an error stops a subunit, e.g. dead context.
// - while bit 24 set, events of failed contexts are blocked.
// - bit 23 sets when received cycle start disagrees with local timer.
// - bit 20 sets each time the timer count lsb toggles.
// - bit 16 clears at the moment bit 17 sets.
// - bit 15 sets with bit 16 and ignores bus reset.
// - bit 18 sets before next access when access fails on missing clock.
`include "link_irq_map.svh"

module link_interrupt_event_bank #(
  parameter int OVERLONG_CYCLES = `OVERLONG_CYCLES,
  parameter int NUM_CONTEXTS    = 8
) (
  // clock and reset
  input  wire logic                    REF_CLK,
  input  wire logic                    SRST,
  // avalon-mm slave
  input  wire logic [7:0]              ADDRESS,
  input  wire logic                    READ,
  input  wire logic                    WRITE,
  input  wire logic [31:0]             WRITEDATA,
  input  wire logic [3:0]              BYTEENABLE,
  output logic [31:0]                  READDATA,
  output logic                         WAITREQUEST,
  // interrupt
  output logic                         IRQ,
  // general-purpose interrupt pins
  input  wire logic                    GP_INPUT_A,
  input  wire logic                    GP_INPUT_B,
  // late acknowledge conditions
  input  wire logic                    RX_FIFO_PENDING,
  input  wire logic                    PHYS_RESP_BUSY,
  input  wire logic                    TARDY_ACK_SENT,
  // phy register byte
  input  wire logic                    PHY_BYTE_VALID,
  input  wire logic [7:0]              PHY_BYTE,
  // cycle master timing
  input  wire logic                    CYCLE_START_TX,
  input  wire logic                    SUBACTION_GAP_END,
  output logic                         CYCLE_MASTER_ENABLE,
  // dma contexts
  input  wire logic [NUM_CONTEXTS-1:0] CONTEXT_DEAD,
  input  wire logic [NUM_CONTEXTS-1:0] CONTEXT_EVENT,
  // cycle timer
  input  wire logic                    RX_CYCLE_START,
  input  wire logic [6:0]              RX_SECONDS,
  input  wire logic [12:0]             RX_COUNT,
  input  wire logic [6:0]              TIMER_SECONDS,
  input  wire logic [12:0]             TIMER_COUNT,
  // bus and link status
  input  wire logic                    BUS_RESET,
  input  wire logic                    IDENT_DONE,
  input  wire logic                    REG_ACCESS_FAIL
);

  localparam int CW = $clog2(OVERLONG_CYCLES + 1);

  function automatic link_irq_pkg::word_t lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  link_irq_pkg::word_t     event_reg, next_event;
  link_irq_pkg::word_t     mask, next_mask;
  link_irq_pkg::word_t     control, next_control;
  logic [7:0]              phy_byte, next_phy_byte;
  logic [31:0]             next_readdata;
  logic                    next_waitrequest, next_irq;
  logic [1:0]              gp_a_sync, gp_b_sync;
  logic                    gp_a_prev, gp_b_prev;
  logic                    late_prev, bus_prev, ident_prev, lsb_prev;
  logic [NUM_CONTEXTS-1:0] dead_prev, dead_ctx, next_dead_ctx;
  link_irq_pkg::gap_state_t gap_state, next_gap_state;
  logic [CW-1:0]           gap_count, next_gap_count;

  logic                    wr_set, wr_clr, wr_mask, wr_ctl;
  link_irq_pkg::word_t     wmask, hw_set, sw_set, sw_clr, readable;
  logic                    late_cond, bus_rise, overlong;
  logic [NUM_CONTEXTS-1:0] ctx_blocked;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign wmask   = lane_mask(BYTEENABLE);
  assign wr_set  = WRITE && !WAITREQUEST && (ADDRESS == `OFS_EVENT_SET);
  assign wr_clr  = WRITE && !WAITREQUEST && (ADDRESS == `OFS_EVENT_CLEAR);
  assign wr_mask = WRITE && !WAITREQUEST && (ADDRESS == `OFS_EVENT_MASK);
  assign wr_ctl  = WRITE && !WAITREQUEST && (ADDRESS == `OFS_CONTROL);
  // zeros written leave bits alone
  assign sw_set  = wr_set ? (WRITEDATA & wmask) : '0;
  assign sw_clr  = wr_clr ? (WRITEDATA & wmask) : '0;

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  assign late_cond = control[`CTL_LATE_ACK_EN]
                     && (RX_FIFO_PENDING || PHYS_RESP_BUSY || TARDY_ACK_SENT);
  assign bus_rise  = BUS_RESET && !bus_prev;
  assign overlong  = (gap_state == link_irq_pkg::GAP_TIMING)
                     && (gap_count == CW'(OVERLONG_CYCLES));
  assign ctx_blocked = event_reg[`BIT_FATAL] ? dead_ctx : '0;

  always_comb begin
    hw_set = '0;
    hw_set[`BIT_GP_PIN]       = (gp_a_sync[1] && !gp_a_prev && control[`CTL_GP_A_EN])
                                || (gp_b_sync[1] && !gp_b_prev && control[`CTL_GP_B_EN]);
    hw_set[`BIT_LATE_ACK]     = late_cond && !late_prev;
    hw_set[`BIT_PHY_BYTE]     = PHY_BYTE_VALID;
    hw_set[`BIT_OVERLONG]     = overlong;
    hw_set[`BIT_FATAL]        = |(CONTEXT_DEAD & ~dead_prev);
    hw_set[`BIT_MISMATCH]     = RX_CYCLE_START
                                && ((RX_SECONDS != TIMER_SECONDS) || (RX_COUNT != TIMER_COUNT));
    hw_set[`BIT_NEW_CYCLE]    = TIMER_COUNT[0] != lsb_prev;
    hw_set[`BIT_ACCESS_FAIL]  = REG_ACCESS_FAIL;
    hw_set[`BIT_BUS_RESET]    = bus_rise;
    hw_set[`BIT_IDENT_DONE]   = IDENT_DONE && !ident_prev;
    hw_set[`BIT_IDENT_STICKY] = IDENT_DONE && !ident_prev;
    hw_set[NUM_CONTEXTS-1:0]  = CONTEXT_EVENT & ~ctx_blocked;
  end

  // ------------------------------------------------------------
  // event, mask and control registers
  // ------------------------------------------------------------
  always_comb begin
    // hardware set wins over a clear in the same cycle
    next_event = (event_reg & ~sw_clr) | hw_set | sw_set;
    if (bus_rise) begin
      next_event[`BIT_IDENT_DONE] = 1'b0;
    end
    next_event = next_event & `EVENT_IMPL_MASK;
    next_mask = wr_mask ? ((mask & ~wmask) | (WRITEDATA & wmask)) : mask;
    next_mask = next_mask & `EVENT_IMPL_MASK;
    next_control = wr_ctl ? ((control & ~wmask) | (WRITEDATA & wmask)) : control;
    if (overlong) begin
      next_control[`CTL_CYCLE_MASTER] = 1'b0;
    end
    next_phy_byte = PHY_BYTE_VALID ? PHY_BYTE : phy_byte;
    next_dead_ctx = event_reg[`BIT_FATAL] ? (dead_ctx | CONTEXT_DEAD) : CONTEXT_DEAD;
    next_irq = |(next_event & next_mask);
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      event_reg <= `EVENT_RESET;
      mask      <= `MASK_RESET;
      control   <= `CONTROL_RESET;
      phy_byte  <= 8'h00;
      dead_ctx  <= '0;
      IRQ       <= 1'b0;
    end else begin
      event_reg <= next_event;
      mask      <= next_mask;
      control   <= next_control;
      phy_byte  <= next_phy_byte;
      dead_ctx  <= next_dead_ctx;
      IRQ       <= next_irq;
    end
  end

  always_comb begin
    CYCLE_MASTER_ENABLE = control[`CTL_CYCLE_MASTER];
  end

  // ------------------------------------------------------------
  // edge detectors and pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      gp_a_sync  <= 2'b00;
      gp_b_sync  <= 2'b00;
      gp_a_prev  <= 1'b0;
      gp_b_prev  <= 1'b0;
      late_prev  <= 1'b0;
      bus_prev   <= 1'b0;
      ident_prev <= 1'b0;
      lsb_prev   <= 1'b0;
      dead_prev  <= '0;
    end else begin
      gp_a_sync  <= {gp_a_sync[0], GP_INPUT_A};
      gp_b_sync  <= {gp_b_sync[0], GP_INPUT_B};
      gp_a_prev  <= gp_a_sync[1];
      gp_b_prev  <= gp_b_sync[1];
      late_prev  <= late_cond;
      bus_prev   <= BUS_RESET;
      ident_prev <= IDENT_DONE;
      lsb_prev   <= TIMER_COUNT[0];
      dead_prev  <= CONTEXT_DEAD;
    end
  end

  // ------------------------------------------------------------
  // cycle start to subaction gap timer
  // ------------------------------------------------------------
  always_comb begin
    next_gap_state = gap_state;
    next_gap_count = gap_count;
    case (gap_state)
      link_irq_pkg::GAP_IDLE: begin
        if (CYCLE_START_TX && control[`CTL_CYCLE_MASTER]) begin
          next_gap_state = link_irq_pkg::GAP_TIMING;
          next_gap_count = '0;
        end
      end
      link_irq_pkg::GAP_TIMING: begin
        if (SUBACTION_GAP_END || overlong || !control[`CTL_CYCLE_MASTER]) begin
          next_gap_state = link_irq_pkg::GAP_IDLE;
        end else begin
          next_gap_count = gap_count + CW'(1);
        end
      end
      default: next_gap_state = link_irq_pkg::GAP_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      gap_state <= link_irq_pkg::GAP_IDLE;
      gap_count <= '0;
    end else begin
      gap_state <= next_gap_state;
      gap_count <= next_gap_count;
    end
  end

  // ------------------------------------------------------------
  // bus answer: one wait cycle, then data with waitrequest low
  // ------------------------------------------------------------
  assign readable = event_reg & mask;

  always_comb begin
    next_waitrequest = !((READ || WRITE) && WAITREQUEST);
    next_readdata    = 32'h00000000;
    if (READ && WAITREQUEST) begin
      case (ADDRESS)
        `OFS_EVENT_SET, `OFS_EVENT_CLEAR: next_readdata = readable;
        `OFS_EVENT_MASK: next_readdata = mask;
        `OFS_CONTROL:    next_readdata = control;
        `OFS_PHY_BYTE:   next_readdata = {8'h00, phy_byte, 16'h0000};
        default:         next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      WAITREQUEST <= 1'b1;
      READDATA    <= 32'h00000000;
    end else begin
      WAITREQUEST <= next_waitrequest;
      READDATA    <= next_readdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_read_masked: assert property (
    (!WAITREQUEST && $past(READ) && ($past(ADDRESS) == `OFS_EVENT_CLEAR))
      |-> (READDATA == ($past(event_reg) & $past(mask))))
    else $error("event read not masked");

  a_reserved_zero: assert property (
    !READDATA[`BIT_RSVD_HI] && !READDATA[`BIT_RSVD_LO]
      && !event_reg[`BIT_RSVD_HI] && !event_reg[`BIT_RSVD_LO])
    else $error("reserved event bit set");

  a_soft_clear_only: assert property (
    $fell(event_reg[`BIT_SOFTWARE])
      |-> $past(wr_clr && WRITEDATA[`BIT_SOFTWARE] && BYTEENABLE[3]))
    else $error("software bit cleared without clear write");

  a_soft_set: assert property (
    (wr_set && WRITEDATA[`BIT_SOFTWARE] && BYTEENABLE[3]) |=> event_reg[`BIT_SOFTWARE])
    else $error("software bit not set by write");

  a_gp_pin_set: assert property (
    (gp_a_sync[1] && !gp_a_prev && control[`CTL_GP_A_EN]) |=> event_reg[`BIT_GP_PIN])
    else $error("general purpose event missed");

  a_phy_byte_kept: assert property (
    PHY_BYTE_VALID |=> (event_reg[`BIT_PHY_BYTE] && (phy_byte == $past(PHY_BYTE))))
    else $error("phy byte event or data wrong");

  a_overlong_master: assert property (
    $rose(event_reg[`BIT_OVERLONG]) && $past(overlong) |-> !CYCLE_MASTER_ENABLE)
    else $error("cycle master not cleared on overlong cycle");

  a_overlong_time: assert property (
    (gap_state == link_irq_pkg::GAP_IDLE) ##1 (gap_state == link_irq_pkg::GAP_TIMING)
      |-> (gap_count == '0))
    else $error("gap timer not restarted");

  a_ident_cleared: assert property (
    bus_rise |=> (event_reg[`BIT_BUS_RESET] && !event_reg[`BIT_IDENT_DONE]))
    else $error("identification done not cleared on bus reset");

  a_ident_sticky: assert property (
    (IDENT_DONE && !ident_prev) |=> event_reg[`BIT_IDENT_STICKY])
    else $error("sticky identification bit missing");

  a_access_fail: assert property (
    REG_ACCESS_FAIL |=> event_reg[`BIT_ACCESS_FAIL])
    else $error("access failure not flagged");

  a_new_cycle: assert property (
    $changed(TIMER_COUNT[0]) |=> event_reg[`BIT_NEW_CYCLE])
    else $error("new cycle event missed");

  a_bus_answer: assert property (
    ((READ || WRITE) && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus answer timing wrong");

endmodule

// [design/link_irq_map.svh]
// offsets, bit positions, reset values and timing counts of the interrupt event bank
`ifndef LINK_IRQ_MAP_SVH
`define LINK_IRQ_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_EVENT_SET   8'h80
`define OFS_EVENT_CLEAR 8'h84
`define OFS_EVENT_MASK  8'h88
`define OFS_CONTROL     8'h8c
`define OFS_PHY_BYTE    8'h90

// ------------------------------------------------------------
// event bit positions
// ------------------------------------------------------------
`define BIT_RSVD_HI         31
`define BIT_GP_PIN          30
`define BIT_SOFTWARE        29
`define BIT_RSVD_LO         28
`define BIT_LATE_ACK        27
`define BIT_PHY_BYTE        26
`define BIT_OVERLONG        25
`define BIT_FATAL           24
`define BIT_MISMATCH        23
`define BIT_NEW_CYCLE       20
`define BIT_ACCESS_FAIL     18
`define BIT_BUS_RESET       17
`define BIT_IDENT_DONE      16
`define BIT_IDENT_STICKY    15

// implemented event bits: 30,29,27..23,20,18..15,7..0
`define EVENT_IMPL_MASK     32'h6f9780ff
`define EVENT_RESET         32'h00000000
`define MASK_RESET          32'h00000000

// ------------------------------------------------------------
// control register fields and phy byte position
// ------------------------------------------------------------
`define CTL_GP_B_EN         31
`define CTL_LATE_ACK_EN     29
`define CTL_GP_A_EN         23
`define CTL_CYCLE_MASTER    21
`define CONTROL_RESET       32'h00000000
`define PHY_BYTE_LSB        16

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ             125
`define OVERLONG_US         125
`define OVERLONG_CYCLES     (`OVERLONG_US * `CLK_MHZ)

`endif

// [design/link_irq_pkg.sv]
// types shared by the interrupt event bank
package link_irq_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [0:0] {GAP_IDLE, GAP_TIMING} gap_state_t;
endpackage

// [tb/link_interrupt_event_bank_tb_top.sv]
// self-checking bench of the interrupt event bank
`include "link_irq_map.svh"
module link_interrupt_event_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // stimulus and model state
  // ------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        cme;
  logic [11:0] src = 12'h000;
  logic [7:0]  ctx_dead = 8'h00;
  logic [7:0]  ctx_ev = 8'h00;
  logic [7:0]  phy_byte = 8'h00;
  logic [6:0]  rx_sec = 7'h00;
  logic [6:0]  tmr_sec = 7'h00;
  logic [12:0] rx_cnt = 13'h0000;
  logic [12:0] tmr_cnt = 13'h0000;
  logic [31:0] exp_ev = 32'h00000000;
  logic [31:0] mask = 32'h00000000;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] tab [10];
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 32'hbcfe;

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  link_interrupt_event_bank #(.OVERLONG_CYCLES(20)) u_link_interrupt_event_bank (
    .REF_CLK(ref_clk), .SRST(srst), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .IRQ(irq), .GP_INPUT_A(src[0]), .GP_INPUT_B(src[1]),
    .RX_FIFO_PENDING(src[2]), .PHYS_RESP_BUSY(src[3]), .TARDY_ACK_SENT(src[4]),
    .PHY_BYTE_VALID(src[5]), .PHY_BYTE(phy_byte), .CYCLE_START_TX(src[10]),
    .SUBACTION_GAP_END(src[11]), .CYCLE_MASTER_ENABLE(cme), .CONTEXT_DEAD(ctx_dead),
    .CONTEXT_EVENT(ctx_ev), .RX_CYCLE_START(src[9]), .RX_SECONDS(rx_sec),
    .RX_COUNT(rx_cnt), .TIMER_SECONDS(tmr_sec), .TIMER_COUNT(tmr_cnt),
    .BUS_RESET(src[7]), .IDENT_DONE(src[8]), .REG_ACCESS_FAIL(src[6]));

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dv);
    int n;
    @(posedge ref_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= dv;
    // request stands until the edge that samples waitrequest low
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rd, e);
  endtask

  // both addresses read the masked events, irq follows them
  task automatic evchk();
    rchk(`OFS_EVENT_SET, exp_ev & mask);
    rchk(`OFS_EVENT_CLEAR, exp_ev & mask);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, |(exp_ev & mask)});
  endtask

  task automatic clr_all();
    bus(1'b1, `OFS_EVENT_CLEAR, 32'hffffffff);
    exp_ev = 32'h00000000;
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    src[i] <= 1'b1;
    @(posedge ref_clk);
    src[i] <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  initial begin
    #500000;
    miscompares++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tab = '{32'h40000000, 32'h40000000, 32'h08000000, 32'h08000000, 32'h08000000,
            32'h04000000, 32'h00040000, 32'h00020000, 32'h00018000, 32'h00800000};
    phy_byte = 8'($random(seed));
    tmr_sec = 7'($random(seed));
    rx_sec = tmr_sec ^ 7'h01;
    tmr_cnt = 13'($random(seed)) & 13'h1ffe;
    rx_cnt = tmr_cnt;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    evchk();
    rchk(`OFS_EVENT_MASK, `MASK_RESET);
    rchk(`OFS_CONTROL, `CONTROL_RESET);
    bus(1'b1, 8'ha0, 32'hffffffff);
    rchk(8'ha0, 32'h00000000);
    bus(1'b1, `OFS_EVENT_MASK, 32'hffffffff);
    mask = `EVENT_IMPL_MASK;
    rchk(`OFS_EVENT_MASK, mask);
    bus(1'b1, `OFS_EVENT_SET, 32'hffffffff);
    exp_ev = mask;
    evchk();
    bus(1'b1, `OFS_EVENT_SET, 32'h00000000);
    bus(1'b1, `OFS_EVENT_CLEAR, 32'h00000000);
    evchk();
    bus(1'b1, `OFS_EVENT_CLEAR, 32'h20000000);
    exp_ev = exp_ev & ~32'h20000000;
    evchk();
    clr_all();
    repeat (6) begin
      d = $random(seed);
      bus(1'b1, `OFS_EVENT_SET, d);
      exp_ev = exp_ev | (d & `EVENT_IMPL_MASK);
      d = $random(seed);
      bus(1'b1, `OFS_EVENT_MASK, d);
      mask = d & `EVENT_IMPL_MASK;
      evchk();
      d = $random(seed);
      bus(1'b1, `OFS_EVENT_CLEAR, d);
      exp_ev = exp_ev & ~d;
      evchk();
    end
    clr_all();
    bus(1'b1, `OFS_EVENT_MASK, 32'hffffffff);
    mask = `EVENT_IMPL_MASK;
    // sources without their enables
    pulse(0);
    pulse(1);
    pulse(2);
    evchk();
    bus(1'b1, `OFS_CONTROL, 32'ha0800000);
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      exp_ev = exp_ev | tab[i];
      evchk();
      clr_all();
    end
    rchk(`OFS_PHY_BYTE, {8'h00, phy_byte, 16'h0000});
    pulse(8);
    pulse(7);
    exp_ev = 32'h00028000;
    evchk();
    clr_all();
    @(posedge ref_clk);
    rx_sec <= tmr_sec;
    pulse(9);
    evchk();
    @(posedge ref_clk);
    rx_cnt <= tmr_cnt ^ 13'h0100;
    pulse(9);
    exp_ev = 32'h00800000;
    evchk();
    clr_all();
    @(posedge ref_clk);
    tmr_cnt <= tmr_cnt ^ 13'h0001;
    repeat (4) @(posedge ref_clk);
    exp_ev = 32'h00100000;
    evchk();
    clr_all();
    @(posedge ref_clk);
    ctx_dead <= 8'h01;
    repeat (4) @(posedge ref_clk);
    ctx_ev <= 8'h03;
    @(posedge ref_clk);
    ctx_ev <= 8'h00;
    repeat (3) @(posedge ref_clk);
    exp_ev = 32'h01000002;
    evchk();
    bus(1'b1, `OFS_EVENT_CLEAR, 32'h01000000);
    ctx_ev <= 8'h01;
    @(posedge ref_clk);
    ctx_ev <= 8'h00;
    repeat (3) @(posedge ref_clk);
    exp_ev = 32'h00000003;
    evchk();
    clr_all();
    bus(1'b1, `OFS_CONTROL, 32'h00200000);
    pulse(10);
    pulse(11);
    repeat (40) @(posedge ref_clk);
    evchk();
    rchk(`OFS_CONTROL, 32'h00200000);
    chk({31'h0, cme}, 32'h00000001);
    pulse(10);
    repeat (40) @(posedge ref_clk);
    exp_ev = 32'h02000000;
    evchk();
    rchk(`OFS_CONTROL, 32'h00000000);
    chk({31'h0, cme}, 32'h00000000);
    end_sim();
  end
endmodule
